// [hw/tlf_top.v]
// terminal link flow control, display straps and block-transfer handshake
// What this block does
// - wrap on: passing column 80 emits Return and Linefeed, cursor to next line
// - wrap off: no Return/Linefeed, cursor stays and overwrites column 80
// - overwrite strap on: Return sets latch; home-up, Linefeed, forward tab clear it
// - latch set: space only advances; latch clear: space writes blanks
// - overwrite strap off: latch unreachable, space always writes blanks
// - escape strap on, remote full duplex: keys take no local action (no cursor, write or transfer)
// - full handshake: host trigger, device warning when ready, host trigger, data
// - Enter line mode long, Enter char mode no handshake, sense and f1-f8 short
// - short-trigger and long-warning straps pick handshake type per category
// - data speed select output follows its strap, low by default
// - transmitted parity bit sits in the byte's top bit
// - parity check strap on with odd/even parity checks each received byte
// - forced zero or one parity never checks received parity
// - ENQ answered with ACK after input buffer fully processed
// - ENQ/ACK off: ENQ is plain data, no ACK ever
// - transmit handshake on: pause sending while clear-to-send busy
// - XON/XOFF on: send XOFF when buffer within 16 bytes of full
// - after XOFF send XON when buffer drains below half
// - XON is control-Q, XOFF is control-S
// - each strap toggled by next or previous command, shown as case of letter
`include "tlf_defines.vh"
module tlf_top #(
  parameter DEPTH   = 64,
  parameter AW      = 6,
  parameter BIT_CYC = `TLF_BIT_CYC
) (
  input  wire       i_sys_clk,    // system clock
  input  wire       i_nrst,       // async reset, low
  input  wire       i_rxd,        // serial in
  input  wire       i_cts_busy,   // clear-to-send busy from host
  input  wire [1:0] i_parity,     // parity kind
  input  wire [9:0] i_strap_tgl,  // toggle pulse per strap
  input  wire       i_remote,     // remote mode
  input  wire       i_full_dup,   // full duplex
  input  wire       i_line_mode,  // line mode strap
  input  wire       i_key_valid,  // key event pulse
  input  wire [3:0] i_key,        // key code
  input  wire [7:0] i_key_char,   // printable char of key
  input  wire       i_drain,      // consumer takes one input byte
  input  wire       i_data_valid, // block data byte offered
  input  wire [7:0] i_data,       // block data byte
  output reg        o_data_ready, // block data byte taken
  output reg        o_txd,        // serial out
  output reg        o_speed_sel,  // data speed select line
  output reg [9:0]  o_straps,     // strap states, 1 upper case
  output reg [6:0]  o_col,        // cursor column 0..79
  output reg        o_row_adv,    // cursor moved to next line
  output reg        o_wr,         // write char at cursor
  output reg [7:0]  o_wr_char,    // char written
  output reg        o_space_overwrite_latch_latch, // space overwrite latch
  output reg        o_in_valid,   // input byte out
  output reg [6:0]  o_in_data,    // input byte
  output reg        o_perr,       // parity error pulse
  output reg [1:0]  o_hs_type     // handshake type of last transfer
);
  // key codes
  localparam K_CHAR = 4'h0, K_SPACE = 4'h1, K_RETURN = 4'h2, K_HOME = 4'h3;
  localparam K_LF   = 4'h4, K_TAB   = 4'h5, K_ENTER  = 4'h6, K_SENSE = 4'h7;
  localparam K_FKEY = 4'h8, K_CUP   = 4'h9;
  // strap bit positions
  localparam S_ESC = 0, S_SPACE_OVERWRITE_LATCH = 1, S_WRAP = 2, S_SHORT = 3, S_LONG = 4;
  localparam S_SPEED = 5, S_PCHK = 6, S_ENQ = 7, S_XMIT = 8, S_XON = 9;
  // transfer states
  localparam T_IDLE = 2'h0, T_TRIG1 = 2'h1, T_TRIG2 = 2'h2, T_DATA = 2'h3;

  reg  [1:0] rs, cs;
  reg  [7:0] buf_mem [0:DEPTH-1];
  reg  [AW:0] wp, rp;
  wire [AW:0] cnt = wp - rp;
  reg        xoff_sent, ack_pend, rx_trig;
  reg  [1:0] tst;
  reg        tx_valid;
  reg  [7:0] tx_byte;
  wire       tx_take;
  wire       rx_v, rx_pe;
  wire [6:0] rx_d;
  wire       rxd_s = rs[1];
  wire       txd_w;
  reg        ack_sent, warn_due;
  reg  [1:0] sel;

  // type per category from the two straps
  function [1:0] hs_pick;
    input [1:0] cat;
    input       sh;
    input       lg;
    begin
      if (cat == `TLF_CAT_CHAR) hs_pick = `TLF_HS_TYPE1;
      else if (cat == `TLF_CAT_SHORT)
        hs_pick = sh ? `TLF_HS_TYPE2 : (lg ? `TLF_HS_TYPE3 : `TLF_HS_TYPE1);
      else
        hs_pick = (lg == sh) ? (lg ? `TLF_HS_TYPE3 : `TLF_HS_TYPE1) :
                  (sh ? `TLF_HS_TYPE1 : `TLF_HS_TYPE3);
    end
  endfunction

  // two-stage synchronisers on the line and clear-to-send pins
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rs <= 2'b11;
      cs <= 2'b00;
    end else begin
      rs <= {rs[0], i_rxd};
      cs <= {cs[0], i_cts_busy};
    end
  end

  tlf_rx #(.BIT_CYC(BIT_CYC)) u_rx (
    .i_sys_clk (i_sys_clk),
    .i_nrst    (i_nrst),
    .i_rxd     (rxd_s),
    .i_parity  (i_parity),
    .i_pchk    (o_straps[S_PCHK]),
    .o_valid   (rx_v),
    .o_data    (rx_d),
    .o_perr    (rx_pe)
  );

  tlf_tx #(.BIT_CYC(BIT_CYC)) u_tx (
    .i_sys_clk (i_sys_clk),
    .i_nrst    (i_nrst),
    .i_valid   (tx_valid),
    .i_data    (tx_byte),
    .i_parity  (i_parity),
    .i_pause   (o_straps[S_XMIT] & cs[1]),
    .o_ready   (tx_take),
    .o_txd     (txd_w)
  );

  // strap toggles; each command flips state
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_straps <= {`TLF_RST_XONOFF, `TLF_RST_XMIT, `TLF_RST_ENQ, `TLF_RST_PCHK,
                   `TLF_RST_SPEED, `TLF_RST_LONG, `TLF_RST_SHORT, `TLF_RST_WRAP,
                   `TLF_RST_SPACE_OVERWRITE_LATCH, `TLF_RST_ESC};
      o_speed_sel <= 1'b0;
      o_txd       <= 1'b1;
    end else begin
      o_straps    <= o_straps ^ i_strap_tgl;
      o_speed_sel <= o_straps[S_SPEED];
      o_txd       <= txd_w;
    end
  end

  // input buffer, ENQ/ACK pending flag, trigger detection
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wp <= {(AW+1){1'b0}};
      rp <= {(AW+1){1'b0}};
      ack_pend   <= 1'b0;
      rx_trig    <= 1'b0;
      o_in_valid <= 1'b0;
      o_in_data  <= 7'h00;
      o_perr     <= 1'b0;
    end else begin
      o_in_valid <= 1'b0;
      o_perr     <= rx_pe;
      rx_trig    <= 1'b0;
      // clear first so a fresh enquiry in the same cycle wins
      if (ack_sent) begin
        ack_pend <= 1'b0;
      end
      if (rx_v) begin
        if (o_straps[S_ENQ] && {1'b0, rx_d} == `TLF_CHR_ENQ) begin
          ack_pend <= 1'b1;
        end else if ({1'b0, rx_d} == `TLF_CHR_TRIG && tst != T_IDLE && tst != T_DATA) begin
          rx_trig <= 1'b1;
        end else if (cnt != DEPTH) begin
          buf_mem[wp[AW-1:0]] <= {1'b0, rx_d};
          wp <= wp + 1'b1;
        end
      end
      if (i_drain && cnt != 0) begin
        o_in_valid <= 1'b1;
        o_in_data  <= buf_mem[rp[AW-1:0]][6:0];
        rp <= rp + 1'b1;
      end
    end
  end

  // transmit arbitration: flow chars, ACK, warning, then block data
  wire want_xoff = o_straps[S_XON] && !xoff_sent && (cnt >= DEPTH - `TLF_XOFF_MARGIN);
  wire want_xon  = o_straps[S_XON] && xoff_sent && (cnt < DEPTH / 2);
  wire ack_ok    = ack_pend && (cnt == 0) && o_straps[S_ENQ];
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tx_valid  <= 1'b0;
      tx_byte   <= 8'h00;
      sel       <= 2'h0;
      xoff_sent <= 1'b0;
      ack_sent  <= 1'b0;
      o_data_ready <= 1'b0;
    end else begin
      ack_sent     <= 1'b0;
      o_data_ready <= 1'b0;
      if (tx_valid) begin
        if (tx_take) begin
          tx_valid <= 1'b0;
          if (sel == 2'h0) xoff_sent <= (tx_byte == `TLF_CHR_XOFF);
          if (sel == 2'h1) ack_sent <= 1'b1;
          if (sel == 2'h3) o_data_ready <= 1'b1;
        end
      end else if (want_xoff) begin
        tx_valid <= 1'b1; tx_byte <= `TLF_CHR_XOFF; sel <= 2'h0;
      end else if (want_xon) begin
        tx_valid <= 1'b1; tx_byte <= `TLF_CHR_XON; sel <= 2'h0;
      end else if (ack_ok && !ack_sent) begin
        tx_valid <= 1'b1; tx_byte <= `TLF_CHR_ACK; sel <= 2'h1;
      end else if (warn_due) begin
        tx_valid <= 1'b1; tx_byte <= `TLF_CHR_WARN; sel <= 2'h2;
      end else if (tst == T_DATA && i_data_valid && !o_data_ready) begin
        tx_valid <= 1'b1; tx_byte <= i_data; sel <= 2'h3;
      end
    end
  end

  // block-transfer handshake sequencer
  reg  [1:0] cat;
  wire       esc_mode = o_straps[S_ESC] && i_remote && i_full_dup;
  wire       start = i_key_valid && !esc_mode &&
                     (i_key == K_ENTER || i_key == K_SENSE || i_key == K_FKEY);
  always @* begin
    if (i_key == K_ENTER) cat = i_line_mode ? `TLF_CAT_LINE : `TLF_CAT_CHAR;
    else cat = `TLF_CAT_SHORT;
  end
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tst       <= T_IDLE;
      warn_due  <= 1'b0;
      o_hs_type <= `TLF_HS_TYPE1;
    end else begin
      if (tx_take && sel == 2'h2 && tx_valid) warn_due <= 1'b0;
      case (tst)
        T_IDLE: begin
          if (start) begin
            o_hs_type <= hs_pick(cat, o_straps[S_SHORT], o_straps[S_LONG]);
            case (hs_pick(cat, o_straps[S_SHORT], o_straps[S_LONG]))
              `TLF_HS_TYPE3: tst <= T_TRIG1;
              `TLF_HS_TYPE2: tst <= T_TRIG2;
              default:       tst <= T_DATA;
            endcase
          end
        end
        T_TRIG1: if (rx_trig) begin
          warn_due <= 1'b1; tst <= T_TRIG2;
        end
        T_TRIG2: if (rx_trig && !warn_due) tst <= T_DATA;
        T_DATA:  if (!i_data_valid && !tx_valid) tst <= T_IDLE;
        default: tst <= T_IDLE;
      endcase
    end
  end

  // cursor, wraparound and overwrite latch
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_col        <= 7'h00;
      o_row_adv    <= 1'b0;
      o_wr         <= 1'b0;
      o_wr_char    <= 8'h00;
      o_space_overwrite_latch_latch <= 1'b0;
    end else begin
      o_row_adv <= 1'b0;
      o_wr      <= 1'b0;
      if (!o_straps[S_SPACE_OVERWRITE_LATCH]) o_space_overwrite_latch_latch <= 1'b0;
      if (i_key_valid && !esc_mode) begin
        case (i_key)
          K_CHAR, K_SPACE: begin
            o_wr      <= (i_key == K_CHAR) || !o_space_overwrite_latch_latch;
            o_wr_char <= (i_key == K_CHAR) ? i_key_char : `TLF_CHR_SP;
            if (o_col == `TLF_LAST_COL) begin
              if (o_straps[S_WRAP]) begin
                o_col <= 7'h00; o_row_adv <= 1'b1;
              end
            end else begin
              o_col <= o_col + 7'h01;
            end
          end
          K_RETURN: begin
            o_col <= 7'h00;
            if (o_straps[S_SPACE_OVERWRITE_LATCH]) o_space_overwrite_latch_latch <= 1'b1;
          end
          K_HOME, K_LF, K_TAB: begin
            if (i_key == K_HOME) o_col <= 7'h00;
            if (i_key == K_LF) o_row_adv <= 1'b1;
            o_space_overwrite_latch_latch <= 1'b0;
          end
          default: o_wr <= 1'b0;
        endcase
      end
    end
  end
endmodule

// [common/tlf_defines.vh]
// constants for the terminal link flow and strap block
`ifndef TLF_DEFINES_VH
`define TLF_DEFINES_VH
`define TLF_LAST_COL     7'd79
`define TLF_CHR_CR       8'h0D
`define TLF_CHR_LF       8'h0A
`define TLF_CHR_SP       8'h20
`define TLF_CHR_ENQ      8'h05
`define TLF_CHR_ACK      8'h06
`define TLF_CHR_XON      8'h11
`define TLF_CHR_XOFF     8'h13
`define TLF_CHR_TRIG     8'h11
`define TLF_CHR_WARN     8'h12
`define TLF_XOFF_MARGIN  16
`define TLF_PAR_ZERO     2'h0
`define TLF_PAR_ONE      2'h1
`define TLF_PAR_ODD      2'h2
`define TLF_PAR_EVEN     2'h3
`define TLF_HS_TYPE1     2'h1
`define TLF_HS_TYPE2     2'h2
`define TLF_HS_TYPE3     2'h3
`define TLF_CAT_LINE     2'h0
`define TLF_CAT_SHORT    2'h1
`define TLF_CAT_CHAR     2'h2
`define TLF_BIT_NS       104167
`define TLF_CLK_NS       10
`define TLF_BIT_CYC      ((`TLF_BIT_NS + `TLF_CLK_NS - 1) / `TLF_CLK_NS)
`define TLF_RST_ESC      1'b0
`define TLF_RST_SPACE_OVERWRITE_LATCH     1'b0
`define TLF_RST_WRAP     1'b1
`define TLF_RST_SHORT    1'b1
`define TLF_RST_LONG     1'b1
`define TLF_RST_SPEED    1'b0
`define TLF_RST_PCHK     1'b1
`define TLF_RST_ENQ      1'b1
`define TLF_RST_XMIT     1'b0
`define TLF_RST_XONOFF   1'b0
`endif

// [hw/tlf_tx.v]
// serial transmitter, 7 data bits plus parity in the top bit
`include "tlf_defines.vh"
module tlf_tx #(
  parameter BIT_CYC = `TLF_BIT_CYC
) (
  input  wire       i_sys_clk, // system clock
  input  wire       i_nrst,    // async reset, low
  input  wire       i_valid,   // byte offered
  input  wire [7:0] i_data,    // byte
  input  wire [1:0] i_parity,  // parity kind
  input  wire       i_pause,   // hold before next byte
  output reg        o_ready,   // byte taken when high with valid
  output reg        o_txd      // serial line
);
  reg [3:0]  bitn;
  reg [9:0]  shift;
  reg [31:0] cnt;
  reg        busy;
  wire [6:0] d7 = i_data[6:0];
  reg        pbit;
  // parity bit by configured kind
  always @* begin
    case (i_parity)
      `TLF_PAR_ZERO: pbit = 1'b0;
      `TLF_PAR_ONE:  pbit = 1'b1;
      `TLF_PAR_ODD:  pbit = ~(^d7);
      default:       pbit = ^d7;
    endcase
  end
  // shifter and bit timer
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      busy    <= 1'b0;
      o_txd   <= 1'b1;
      o_ready <= 1'b0;
      bitn    <= 4'h0;
      cnt     <= 32'h0;
      shift   <= 10'h3FF;
    end else begin
      o_ready <= 1'b0;
      if (!busy) begin
        o_txd <= 1'b1;
        if (i_valid && !i_pause && !o_ready) begin
          shift   <= {1'b1, pbit, d7, 1'b0};
          busy    <= 1'b1;
          o_ready <= 1'b1;
          bitn    <= 4'h0;
          cnt     <= 32'h0;
        end
      end else if (cnt == 32'h0) begin
        o_txd <= shift[0];
        shift <= {1'b1, shift[9:1]};
        cnt   <= BIT_CYC - 1;
        if (bitn == 4'hA) begin
          busy <= 1'b0;
        end
        bitn <= bitn + 4'h1;
      end else begin
        cnt <= cnt - 32'h1;
      end
    end
  end
endmodule

// [hw/tlf_rx.v]
// serial receiver with parity check
`include "tlf_defines.vh"
module tlf_rx #(
  parameter BIT_CYC = `TLF_BIT_CYC
) (
  input  wire       i_sys_clk, // system clock
  input  wire       i_nrst,    // async reset, low
  input  wire       i_rxd,     // synchronised line
  input  wire [1:0] i_parity,  // parity kind
  input  wire       i_pchk,    // check enable
  output reg        o_valid,   // byte pulse
  output reg [6:0]  o_data,    // 7-bit char
  output reg        o_perr     // parity error pulse
);
  reg [3:0]  bitn;
  reg [7:0]  sh;
  reg [31:0] cnt;
  reg        busy;
  wire       forced = (i_parity == `TLF_PAR_ZERO) || (i_parity == `TLF_PAR_ONE);
  wire       bad    = (i_parity == `TLF_PAR_ODD) ? ~(^sh) : (^sh);
  // sample mid-bit
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      busy    <= 1'b0;
      bitn    <= 4'h0;
      sh      <= 8'h00;
      cnt     <= 32'h0;
      o_valid <= 1'b0;
      o_data  <= 7'h00;
      o_perr  <= 1'b0;
    end else begin
      o_valid <= 1'b0;
      o_perr  <= 1'b0;
      if (!busy) begin
        if (!i_rxd) begin
          busy <= 1'b1;
          cnt  <= BIT_CYC + BIT_CYC / 2 - 1; // first sample mid data bit
          bitn <= 4'h0;
        end
      end else if (cnt == 32'h0) begin
        if (bitn == 4'h8) begin
          busy    <= 1'b0;
          o_valid <= 1'b1;
          o_data  <= sh[6:0];
          o_perr  <= i_pchk && !forced && bad;
        end else begin
          sh   <= {i_rxd, sh[7:1]};
          bitn <= bitn + 4'h1;
          cnt  <= BIT_CYC - 1;
        end
      end else begin
        cnt <= cnt - 32'h1;
      end
    end
  end
endmodule

// [testbench/tlf_top_chk.sv]
// port assertions for the terminal strap and link block
module tlf_chk (
  input wire       i_sys_clk,    // clock
  input wire       i_nrst,       // reset, low
  input wire [1:0] i_parity,     // parity kind
  input wire [9:0] i_strap_tgl,  // strap toggles
  input wire       i_remote,     // remote mode
  input wire       i_full_dup,   // full duplex
  input wire       i_key_valid,  // key pulse
  input wire [3:0] i_key,        // key code
  input wire       o_speed_sel,  // speed line
  input wire [9:0] o_straps,     // strap states
  input wire [6:0] o_col,        // cursor column
  input wire       o_row_adv,    // next line
  input wire       o_wr,         // char write
  input wire       o_space_overwrite_latch_latch, // overwrite latch
  input wire       o_perr        // parity error
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_nrst);
  // key strobe that acts locally, escape mode excluded
  wire loc = i_key_valid & ~(o_straps[0] & i_remote & i_full_dup);
  a_strap_flip: assert property (|i_strap_tgl |=>
    o_straps == ($past(o_straps) ^ $past(i_strap_tgl))) else $error("strap flip wrong");
  a_strap_hold: assert property (!(|i_strap_tgl) |=> $stable(o_straps))
    else $error("strap moved alone");
  a_speed_line: assert property ($changed(o_speed_sel) |->
    o_speed_sel == o_straps[5]) else $error("speed line wrong");
  a_latch_off: assert property (!o_straps[1] |=> !o_space_overwrite_latch_latch)
    else $error("latch set while strap off");
  a_latch_set: assert property (loc && i_key == 4'h2 && o_straps[1] |=> o_space_overwrite_latch_latch)
    else $error("latch not set");
  a_latch_clr: assert property (loc && i_key inside {4'h3, 4'h4, 4'h5} |=>
    !o_space_overwrite_latch_latch) else $error("latch not cleared");
  a_space_skip: assert property (loc && i_key == 4'h1 && o_space_overwrite_latch_latch |=> !o_wr)
    else $error("space wrote under latch");
  a_wrap_on: assert property (loc && i_key == 4'h0 && o_col == 7'h4F && o_straps[2] |->
    ##[1:3] (o_row_adv && o_col == 7'h00)) else $error("no wrap");
  a_wrap_off: assert property (loc && i_key == 4'h0 && o_col == 7'h4F && !o_straps[2] |=>
    (o_col == 7'h4F && !o_row_adv) [*3]) else $error("wrapped while off");
  a_col_range: assert property (o_col <= 7'h4F)
    else $error("column past end");
  a_forced_par: assert property (!i_parity[1] |-> !o_perr)
    else $error("forced parity checked");
  a_pchk_off: assert property (!o_straps[6] |-> !o_perr)
    else $error("check while off");
endmodule
bind tlf_top tlf_chk i_chk (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_parity(i_parity),
  .i_strap_tgl(i_strap_tgl), .i_remote(i_remote), .i_full_dup(i_full_dup),
  .i_key_valid(i_key_valid), .i_key(i_key), .o_speed_sel(o_speed_sel), .o_straps(o_straps),
  .o_col(o_col), .o_row_adv(o_row_adv), .o_wr(o_wr), .o_space_overwrite_latch_latch(o_space_overwrite_latch_latch),
  .o_perr(o_perr));

// [testbench/tlf_host.sv]
// host computer model on the serial line
module tlf_host #(
  parameter BIT_CYC = 4
) (
  input  wire  i_sys_clk, // clock
  input  wire  i_txd,     // terminal serial out
  output logic o_rxd      // serial into terminal
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got [$]; // bytes heard
  logic       stopped; // held off by terminal
  initial begin
    o_rxd = 1'h1;
    stopped = 1'h0;
  end
  // frame receiver, sampled mid-bit
  always begin : rx
    logic [7:0] b;
    @(negedge i_txd);
    repeat (BIT_CYC / 2) @(posedge i_sys_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge i_sys_clk);
      b[i] = i_txd;
    end
    repeat (BIT_CYC) @(posedge i_sys_clk);
    got.push_back(b);
    if (b[6:0] == 7'h13) stopped = 1'h1;
    if (b[6:0] == 7'h11) stopped = 1'h0;
  end
  // one frame to the terminal, called and left just after an edge
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'h1, b, 1'h0};
    for (int i = 0; i < 10; i++) begin
      #1 o_rxd = f[i];
      repeat (BIT_CYC) @(posedge i_sys_clk);
    end
    #1;
  endtask
endmodule

// [testbench/testbench.sv]
// self-checking bench for the terminal strap and link block
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 0, nrst = 0, rxd, cts = 0, rem = 0, dup = 0, lm = 0;
  logic       kv = 0, drn = 0, dv = 0, drdy, txd, spd, radv, wr, lat, iv, perr;
  logic [1:0] par = 0, hst;
  logic [3:0] key = 0;
  logic [7:0] kc = 0, dat = 0, wch;
  logic [9:0] tgl = 0, straps;
  logic [6:0] col, idat, last_in;
  int         n_fail = 0, total_checks = 0, n_adv = 0, n_wr = 0, n_perr = 0;
  tlf_top #(.BIT_CYC(4)) i_tlf_top (
    .i_sys_clk(clk), .i_nrst(nrst), .i_rxd(rxd), .i_cts_busy(cts), .i_parity(par),
    .i_strap_tgl(tgl), .i_remote(rem), .i_full_dup(dup), .i_line_mode(lm),
    .i_key_valid(kv), .i_key(key), .i_key_char(kc), .i_drain(drn), .i_data_valid(dv),
    .i_data(dat), .o_data_ready(drdy), .o_txd(txd), .o_speed_sel(spd), .o_straps(straps),
    .o_col(col), .o_row_adv(radv), .o_wr(wr), .o_wr_char(wch), .o_space_overwrite_latch_latch(lat),
    .o_in_valid(iv), .o_in_data(idat), .o_perr(perr), .o_hs_type(hst));
  tlf_host #(.BIT_CYC(4)) i_host (.i_sys_clk(clk), .i_txd(txd), .o_rxd(rxd));
  // 100 MHz clock
  always #5 clk = ~clk;
  // event counters, offered byte withdrawn once taken
  always @(posedge clk) begin
    if (radv) n_adv++;
    if (wr) n_wr++;
    if (perr) n_perr++;
    if (iv) last_in <= idat;
    if (drdy) dv <= 1'h0;
  end
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %0h exp %0h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rst;
    nrst = 1'h0;
    dv = 1'h0;
    tick(8);
    nrst = 1'h1;
    tick(2);
  endtask
  task automatic tog(input logic [9:0] b);
    tgl = b;
    tick(1);
    tgl = 10'h000;
    tick(2);
  endtask
  task automatic press(input logic [3:0] k, input logic [7:0] c);
    key = k;
    kc = c;
    kv = 1'h1;
    tick(1);
    kv = 1'h0;
    tick(3);
  endtask
  task automatic drain;
    drn = 1'h1;
    tick(1);
    drn = 1'h0;
    tick(2);
  endtask
  task automatic wait_got(input int n);
    int k;
    for (k = 0; k < 3000 && i_host.got.size() < n; k++) tick(1);
    if (k == 3000) begin
      n_fail++;
      end_of_test;
    end
  endtask
  // frame with parity in the top bit
  function automatic logic [7:0] fr(input logic [6:0] c, input logic [1:0] p);
    fr = {p[1] ? (^c ^ ~p[0]) : p[0], c};
  endfunction
  // handshake type per short strap, long strap and category
  function automatic logic [1:0] hs_exp(input logic s, l, input logic [1:0] cat);
    if (cat == 2'h2) hs_exp = 2'h1;
    else if (cat == 2'h1) hs_exp = s ? 2'h2 : (l ? 2'h3 : 2'h1);
    else hs_exp = l ? 2'h3 : 2'h1;
  endfunction
  task automatic t_straps;
    check({straps, spd, hst}, {10'h0DC, 1'h0, 2'h1});
    for (int i = 0; i < 10; i++) begin
      tog(10'h001 << i);
      check(straps, 10'h0DC ^ (10'h001 << i));
      check(spd, i == 5);
      tog(10'h001 << i);
    end
  endtask
  task automatic t_wrap;
    int a, w;
    a = n_adv;
    for (int i = 0; i < 80; i++) press(4'h0, 8'h41);
    check(col, 7'h00);
    check(n_adv - a, 1);
    tog(10'h004);
    a = n_adv;
    w = n_wr;
    for (int i = 0; i < 81; i++) press(4'h0, 8'h42);
    check({col, wch}, {7'h4F, 8'h42});
    check({8'(n_adv - a), 8'(n_wr - w)}, {8'h00, 8'h51});
    tog(10'h004);
  endtask
  task automatic t_space_overwrite_latch;
    int w;
    press(4'h2, 8'h00);
    w = n_wr;
    press(4'h1, 8'h20);
    check({lat, 7'(n_wr - w), wch}, {1'h0, 7'h01, 8'h20});
    tog(10'h002);
    for (int k = 3; k < 6; k++) begin
      press(4'h2, 8'h00);
      check(lat, 1'h1);
      w = n_wr;
      press(4'h1, 8'h20);
      check(n_wr - w, 0);
      press(k[3:0], 8'h00);
      check(lat, 1'h0);
    end
    w = n_wr;
    press(4'h1, 8'h20);
    check(n_wr - w, 1);
    tog(10'h003);
    rem = 1'h1;
    dup = 1'h1;
    w = n_wr;
    press(4'h0, 8'h43);
    check(n_wr - w, 0);
    rem = 1'h0;
    dup = 1'h0;
    press(4'h0, 8'h43);
    check(n_wr - w, 1);
    tog(10'h001);
  endtask
  task automatic t_par;
    int p0;
    for (int p = 0; p < 4; p++) begin
      par = p[1:0];
      p0 = n_perr;
      i_host.send(fr(7'h41, par) ^ 8'h80);
      i_host.send(fr(7'h42, par));
      tick(4);
      check(n_perr - p0, p > 1);
      drain;
      drain;
      check(last_in, 7'h42);
    end
    tog(10'h040);
    p0 = n_perr;
    i_host.send(fr(7'h41, par) ^ 8'h80);
    tick(4);
    check(n_perr - p0, 0);
    drain;
    tog(10'h040);
  endtask
  task automatic t_enq;
    int g;
    par = 2'h2;
    g = i_host.got.size();
    i_host.send(fr(7'h41, par));
    i_host.send(fr(7'h05, par));
    tick(60);
    check(i_host.got.size() - g, 0);
    drain;
    wait_got(g + 1);
    check(i_host.got[g], fr(7'h06, par));
    tog(10'h080);
    i_host.send(fr(7'h05, par));
    tick(4);
    drain;
    tick(60);
    check({last_in, 8'(i_host.got.size() - g)}, {7'h05, 8'h01});
    tog(10'h080);
  endtask
  task automatic t_hs;
    for (int c = 0; c < 4; c++) begin
      for (int t = 0; t < 4; t++) begin
        rst;
        tog(10'(c) << 3);
        lm = (t == 0);
        press((t == 1) ? 4'h7 : (t == 2) ? 4'h8 : 4'h6, 8'h00);
        check(hst, hs_exp(!c[0], !c[1], (t == 3) ? 2'h2 : 2'(t > 0)));
      end
    end
  endtask
  task automatic t_walk;
    int g;
    rst;
    par = 2'h0;
    lm = 1'h1;
    dat = 8'h41;
    dv = 1'h1;
    g = i_host.got.size();
    press(4'h6, 8'h00);
    tick(100);
    check(i_host.got.size() - g, 0);
    i_host.send(8'h11);
    wait_got(g + 1);
    check(i_host.got[g], 8'h12);
    tick(60);
    check(i_host.got.size() - g, 1);
    i_host.send(8'h11);
    wait_got(g + 2);
    check(i_host.got[g + 1], 8'h41);
  endtask
  task automatic t_cts;
    int g;
    for (int x = 0; x < 2; x++) begin
      rst;
      if (x == 1) tog(10'h100);
      cts = 1'h1;
      lm = 1'h0;
      g = i_host.got.size();
      dat = 8'h42;
      dv = 1'h1;
      press(4'h6, 8'h00);
      tick(200);
      check(i_host.got.size() - g, 1 - x);
      cts = 1'h0;
      wait_got(g + 1);
      check(i_host.got[g], 8'h42);
    end
  endtask
  task automatic t_xon;
    int g, n, m;
    rst;
    tog(10'h200);
    g = i_host.got.size();
    for (n = 0; n < 64 && !i_host.stopped; n++) i_host.send(8'h30);
    check(n >= 46 && n <= 52, 1);
    check(i_host.got[g], 8'h13);
    tick(200);
    check(i_host.got.size() - g, 1);
    for (m = 0; m < n && i_host.got.size() == g + 1; m++) begin
      drain;
      tick(50);
    end
    check(n - m, 31);
    check(i_host.got[g + 1], 8'h11);
    for (; m < n; m++) drain;
    tick(100);
    check(i_host.got.size() - g, 2);
  endtask
  // main sequence
  initial begin
    rst;
    t_straps;
    t_wrap;
    t_space_overwrite_latch;
    t_par;
    t_enq;
    t_hs;
    t_walk;
    t_cts;
    t_xon;
    end_of_test;
  end
endmodule
